// file: bas_pkg.sv
package bas_pkg;
    localparam int ADDR_W         = 24;
    localparam int DATA_W         = 16;
    localparam int OP_W           = 64;
    // operand sizes
    typedef enum logic [1:0] {
        BAS_SZ_BYTE,
        BAS_SZ_WORD,
        BAS_SZ_DWORD,
        BAS_SZ_QWORD
    } bas_size_e;
    // hbe_n / a0 per cycle kind
    localparam logic [1:0] KIND_EVEN_BYTE = 2'h2;
    localparam logic [1:0] KIND_ODD_BYTE  = 2'h1;
    localparam logic [1:0] KIND_EVEN_WORD = 2'h0;
    localparam logic [3:0] CYC_FIRST_LEN  = 4'h4;
    localparam logic [1:0] SYNC_STAGES    = 2'h1;
    localparam logic [3:0] STATUS_RESET   = 4'h0;
    localparam logic [3:0] BYTE_CNT_DW    = 4'h4;
endpackage

// file: bas_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bas_lane_if;
    logic [1:0]  kind;
    logic [2:0]  byte_idx;
    logic [63:0] op_data;
    logic [15:0] lanes;
    logic [1:0]  lane_oe;
    modport ctl (output kind, output byte_idx, output op_data,
                 input lanes, input lane_oe);
    modport steer (input kind, input byte_idx, input op_data,
                   output lanes, output lane_oe);
endinterface
`default_nettype wire

// file: bas_lane_steer.sv
`timescale 1ns/1ps
`default_nettype none
module bas_lane_steer
    import bas_pkg::*;
(
    bas_lane_if.steer lif    // cycle kind and operand in, lanes out
);
    logic [7:0] b0;
    logic [7:0] b1;
    always_comb begin
        b0 = lif.op_data[{lif.byte_idx, 3'h0} +: 8];
        b1 = lif.op_data[{lif.byte_idx + 3'h1, 3'h0} +: 8];
        lif.lanes   = 16'h0000;
        lif.lane_oe = 2'h0;
        unique case (lif.kind)
            KIND_ODD_BYTE: begin
                lif.lanes   = {b0, 8'h00};
                lif.lane_oe = 2'h2;
            end
            KIND_EVEN_BYTE: begin
                lif.lanes   = {8'h00, b0};
                lif.lane_oe = 2'h1;
            end
            default: begin
                lif.lanes   = {b1, b0};
                lif.lane_oe = 2'h3;
            end
        endcase
    end
endmodule
`default_nettype wire

// file: bas_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - 24-bit byte address, any alignment
// - low bank a0 low, high bank hbe
// - three cycle kinds by hbe and a0
// - multi-cycle operands run back to back
// - odd word and dword splitting
// - even dword two word cycles
// - quad word as two dword halves
// - float bus before grant acknowledge
// - ale high from T4 while granted
// - follow requester strobes while granted
// - request removal ends the grant
// - finish cycle; idle grants next clock
// - late request lets one cycle start
// - internal started cycle delays grant
// - cycle status undefined while granted
// - interlock held across grant
// - pulse begin output per instruction
// - status timed by execution section
// - user output follows psr user bit
// - interlock during locked bit ops
// - user high, supervisor low
// - single synchroniser stage on request
module bas_seq
    import bas_pkg::*;
(
    input  wire logic        clk,                 // 25 MHz bus clock
    input  wire logic        rst_b,               // async reset, low
    input  wire logic        op_req,              // start operand access
    input  wire logic [23:0] op_addr,             // operand byte address
    input  wire logic [1:0]  op_size,             // bas_size_e code
    input  wire logic        op_write,            // 1 = write
    input  wire logic [63:0] op_wdata,            // write operand
    output logic             op_busy,             // access in progress
    output logic             op_half_done,        // quad low half finished
    input  wire logic        op_half_go,          // start quad upper half
    output logic             op_done,             // access finished pulse
    input  wire logic        instr_start,         // execution begins insn
    input  wire logic        psr_user,            // psr user bit
    input  wire logic        locked_insn,         // set/clear bit locked
    input  wire logic [3:0]  cyc_status_in,       // status from core
    input  wire logic        bus_req_n,           // hold request pin
    output logic             bus_grant_ack_n,     // hold acknowledge
    output logic [15:0]      addr_data_bus_o,     // ad out
    output logic [15:0]      addr_data_bus_oe,    // ad enables
    output logic [7:0]       upper_address_o,     // upper_address
    output logic             upper_address_oe,    // upper_address enable
    output logic             addr_bit_zero,       // a0
    output logic             high_byte_enable_n,  // hbe out
    output logic             high_byte_enable_oe, // hbe enable
    output logic             address_strobe_n_o,  // ads out
    output logic             address_strobe_n_oe, // ads enable
    input  wire logic        address_strobe_n_i,  // ads in (granted)
    output logic             data_direction_n_o,  // data_direction_n out
    output logic             data_direction_n_oe, // data_direction_n enable
    input  wire logic        data_direction_n_i,  // data_direction_n in (granted)
    output logic             ale,                 // address latch enable
    output logic             timing_state_out_n,  // tso
    output logic             data_buffer_en_n,    // dbe
    output logic             rd_n,                // read strobe
    output logic             wr_n,                // write strobe
    output logic [3:0]       cycle_status,        // cycle_status
    output logic             instr_begin_pulse_n, // pfs
    output logic             user_mode,           // u/s
    output logic             interlock_active_n   // ilo
);
    import bas_pkg::*;

    typedef enum {
        BAS_IDLE, BAS_T1, BAS_T2, BAS_T3, BAS_T4, BAS_HALF, BAS_GRANT
    } bas_st_e;

    bas_st_e     st_q;
    logic        req_sync_q;
    logic [23:0] addr_q;
    logic [3:0]  left_q;
    logic [2:0]  bidx_q;
    logic        wr_q;
    logic        quad_q;
    logic [63:0] data_q;
    logic [1:0]  kind_d;
    logic        ext_t_q;
    logic        ads_i_s1_q;
    logic        ads_i_q;
    logic        data_direction_n_s1_q;
    logic        data_direction_n_q;
    logic [1:0]  ext_ph_q;
    logic [3:0]  total_d;

    bas_lane_if lif();
    bas_lane_steer u_steer (.lif(lif));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) req_sync_q <= 1'b1;
        else        req_sync_q <= bus_req_n;
    end

    // kind from address and bytes left
    always_comb begin
        if (addr_q[0])         kind_d = KIND_ODD_BYTE;
        else if (left_q == 4'h1) kind_d = KIND_EVEN_BYTE;
        else                   kind_d = KIND_EVEN_WORD;
    end

    always_comb begin
        unique case (op_size)
            2'h0:    total_d = 4'h1;
            2'h1:    total_d = 4'h2;
            default: total_d = BYTE_CNT_DW;
        endcase
    end

    assign lif.kind     = kind_d;
    assign lif.byte_idx = bidx_q;
    assign lif.op_data  = data_q;

    // main cycle sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= BAS_IDLE;
            addr_q <= 24'h000000;
            left_q <= 4'h0;
            bidx_q <= 3'h0;
            wr_q   <= 1'b0;
            quad_q <= 1'b0;
            data_q <= 64'h0;
        end else begin
            unique case (st_q)
                BAS_IDLE: begin
                    if (!req_sync_q) st_q <= BAS_GRANT;
                    else if (op_req) begin
                        addr_q <= op_addr;
                        left_q <= total_d;
                        bidx_q <= 3'h0;
                        wr_q   <= op_write;
                        quad_q <= (op_size == 2'h3);
                        data_q <= op_wdata;
                        st_q   <= BAS_T1;
                    end
                end
                BAS_T1: st_q <= BAS_T2;
                BAS_T2: st_q <= BAS_T3;
                BAS_T3: st_q <= BAS_T4;
                BAS_T4: begin
                    if (kind_d == KIND_EVEN_WORD) begin
                        addr_q <= addr_q + 24'h2;
                        left_q <= left_q - 4'h2;
                        bidx_q <= bidx_q + 3'h2;
                    end else begin
                        addr_q <= addr_q + 24'h1;
                        left_q <= left_q - 4'h1;
                        bidx_q <= bidx_q + 3'h1;
                    end
                    if (!req_sync_q) st_q <= BAS_GRANT;
                    else if (left_q > 4'h2 || (left_q == 4'h2
                             && kind_d == KIND_ODD_BYTE))
                        st_q <= BAS_T1;
                    else if (quad_q) st_q <= BAS_HALF;
                    else st_q <= BAS_IDLE;
                end
                // upper half at A+4 after gap
                BAS_HALF: begin
                    if (!req_sync_q) st_q <= BAS_GRANT;
                    else if (op_half_go) begin
                        quad_q <= 1'b0;
                        left_q <= BYTE_CNT_DW;
                        st_q   <= BAS_T1;
                    end
                end
                BAS_GRANT: begin
                    if (req_sync_q)
                        st_q <= (left_q != 4'h0) ? BAS_T1
                              : (quad_q ? BAS_HALF : BAS_IDLE);
                end
                default: st_q <= BAS_IDLE;
            endcase
        end
    end

    // the odd dword/quad end case: T4 leaves left 0 after final byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op_busy      <= 1'b0;
            op_done      <= 1'b0;
            op_half_done <= 1'b0;
        end else begin
            op_busy <= (st_q != BAS_IDLE) || op_req;
            op_done <= (st_q == BAS_T4) && !quad_q &&
                       (left_q == 4'h1 || (left_q == 4'h2 &&
                        kind_d == KIND_EVEN_WORD));
            op_half_done <= (st_q == BAS_T4) && quad_q &&
                       (left_q == 4'h1 || (left_q == 4'h2 &&
                        kind_d == KIND_EVEN_WORD));
        end
    end

    // external cycle tracking while granted, inputs double synced
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ads_i_s1_q <= 1'b1;
            ads_i_q    <= 1'b1;
            data_direction_n_s1_q  <= 1'b1;
            data_direction_n_q     <= 1'b1;
            ext_ph_q   <= 2'h0;
            ext_t_q    <= 1'b0;
        end else begin
            ads_i_s1_q <= address_strobe_n_i;
            ads_i_q    <= ads_i_s1_q;
            data_direction_n_s1_q  <= data_direction_n_i;
            data_direction_n_q     <= data_direction_n_s1_q;
            if (st_q != BAS_GRANT) begin
                ext_ph_q <= 2'h0;
                ext_t_q  <= 1'b0;
            end else if (!ads_i_q && !ext_t_q) begin
                ext_ph_q <= 2'h0;
                ext_t_q  <= 1'b1;
            end else if (ext_t_q) begin
                ext_ph_q <= ext_ph_q + 2'h1;
                if (ext_ph_q == 2'h3) ext_t_q <= 1'b0;
            end
        end
    end

    // pin drivers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_data_bus_o     <= 16'h0000;
            addr_data_bus_oe    <= 16'h0000;
            upper_address_o     <= 8'h00;
            upper_address_oe    <= 1'b0;
            addr_bit_zero       <= 1'b0;
            high_byte_enable_n  <= 1'b1;
            high_byte_enable_oe <= 1'b0;
            address_strobe_n_o  <= 1'b1;
            address_strobe_n_oe <= 1'b0;
            data_direction_n_o  <= 1'b1;
            data_direction_n_oe <= 1'b0;
            ale                 <= 1'b0;
            timing_state_out_n  <= 1'b1;
            data_buffer_en_n    <= 1'b1;
            rd_n                <= 1'b1;
            wr_n                <= 1'b1;
            bus_grant_ack_n     <= 1'b1;
        end else begin
            if (st_q == BAS_GRANT || (st_q != BAS_T1 && st_q != BAS_T2 &&
                st_q != BAS_T3 && !req_sync_q)) begin
                addr_data_bus_oe    <= 16'h0000;
                upper_address_oe    <= 1'b0;
                high_byte_enable_oe <= 1'b0;
                address_strobe_n_oe <= 1'b0;
                data_direction_n_oe <= 1'b0;
                address_strobe_n_o  <= 1'b1;
                ale                 <= 1'b1;
                bus_grant_ack_n     <= (st_q != BAS_GRANT) || req_sync_q;
                timing_state_out_n  <= !(ext_t_q && ext_ph_q != 2'h3);
                data_buffer_en_n    <= !(ext_t_q && ext_ph_q != 2'h0);
                rd_n <= !(ext_t_q && ext_ph_q != 2'h0 && !data_direction_n_q);
                wr_n <= !(ext_t_q && ext_ph_q != 2'h0 && data_direction_n_q);
            end else begin
                bus_grant_ack_n     <= 1'b1;
                upper_address_oe    <= 1'b1;
                high_byte_enable_oe <= 1'b1;
                address_strobe_n_oe <= 1'b1;
                data_direction_n_oe <= 1'b1;
                data_direction_n_o  <= wr_q;
                high_byte_enable_n  <= kind_d[1];
                addr_bit_zero       <= kind_d[0];
                upper_address_o     <= addr_q[23:16];
                address_strobe_n_o  <= !(st_q == BAS_T1);
                ale                 <= (st_q == BAS_T1);
                timing_state_out_n  <= !(st_q == BAS_T2 || st_q == BAS_T3);
                data_buffer_en_n    <= !(st_q == BAS_T2 || st_q == BAS_T3);
                rd_n <= !((st_q == BAS_T2 || st_q == BAS_T3) && !wr_q);
                wr_n <= !((st_q == BAS_T2 || st_q == BAS_T3) && wr_q);
                if (st_q == BAS_T1) begin
                    addr_data_bus_o  <= addr_q[15:0];
                    addr_data_bus_oe <= 16'hffff;
                end else if ((st_q == BAS_T2 || st_q == BAS_T3) && wr_q)
                begin
                    addr_data_bus_o  <= lif.lanes;
                    addr_data_bus_oe <= {{8{lif.lane_oe[1]}},
                                         {8{lif.lane_oe[0]}}};
                end else begin
                    addr_data_bus_oe <= 16'h0000;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_begin_pulse_n <= 1'b1;
            user_mode           <= 1'b0;
            interlock_active_n  <= 1'b1;
            cycle_status        <= STATUS_RESET;
        end else begin
            instr_begin_pulse_n <= !instr_start;
            user_mode           <= psr_user;
            interlock_active_n  <= !locked_insn;
            // held value is meaningless while granted
            cycle_status        <= cyc_status_in;
        end
    end

    // a_grant_float guards bus release
    a_grant_float: assert property (@(posedge clk) disable iff (!rst_b)
        !bus_grant_ack_n |-> addr_data_bus_oe == 16'h0000
            && !upper_address_oe && !high_byte_enable_oe
            && !address_strobe_n_oe && !data_direction_n_oe)
        else $error("bus driven while granted");
    a_ale_granted: assert property (@(posedge clk) disable iff (!rst_b)
        !bus_grant_ack_n |-> ale)
        else $error("ale low during grant");
    a_idle_grant_fast: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == BAS_IDLE && !req_sync_q |=> st_q == BAS_GRANT ##1
            !bus_grant_ack_n)
        else $error("idle grant late");
    a_grant_release: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == BAS_GRANT && req_sync_q |=> st_q != BAS_GRANT ##1
            bus_grant_ack_n)
        else $error("grant not released");
    a_no_mid_grant: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == BAS_T2 |=> st_q == BAS_T3 ##1 st_q == BAS_T4)
        else $error("cycle cut short");
    a_kind_legal: assert property (@(posedge clk) disable iff (!rst_b)
        bus_grant_ack_n && high_byte_enable_oe |->
            !(high_byte_enable_n && addr_bit_zero))
        else $error("illegal hbe a0 pair");
    a_pulse_once: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(instr_start) |=> !instr_begin_pulse_n)
        else $error("begin pulse missing");
    a_user_follow: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 user_mode == $past(psr_user))
        else $error("user output wrong");
    a_lock_hold: assert property (@(posedge clk) disable iff (!rst_b)
        locked_insn |=> !interlock_active_n)
        else $error("interlock dropped");
    a_back_to_back: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == BAS_T4 && req_sync_q && left_q > 4'h2 |=>
            st_q == BAS_T1)
        else $error("idle inserted");
    c_grant: cover property (@(posedge clk) !bus_grant_ack_n);
    c_odd_word: cover property (@(posedge clk)
        st_q == BAS_T1 && kind_d == KIND_ODD_BYTE);
    c_quad_gap: cover property (@(posedge clk) st_q == BAS_HALF);
endmodule
`default_nettype wire

// file: bas_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bas_mem_model (
    input  wire logic        clk,       // bus clock
    input  wire logic        rst_b,     // reset, low
    input  wire logic [15:0] ad,        // address/data lines
    input  wire logic [7:0]  ua,        // upper address
    input  wire logic        a0,        // address bit zero
    input  wire logic        hbe_n,     // high byte enable
    input  wire logic        ads_n,     // strobe wire level
    input  wire logic        rd_n,      // read strobe
    input  wire logic        wr_n,      // write strobe
    input  wire logic        ack_n,     // grant acknowledge
    input  wire logic        dma_go,    // bench wants the bus
    input  wire logic        dma_dir,   // 1 = dma write
    output logic             bus_req_n, // hold request
    output logic             ads_drv,   // driving the address strobe
    output logic             ads_v,     // strobe value
    output logic             data_direction_n_v     // direction value
);
    logic [49:0] log_q[$];
    logic [23:0] addr_q;
    logic [1:0]  kind_q;
    logic [15:0] data_q;
    logic [7:0]  gap_q = 8'h0;
    logic [7:0]  gapl_q;
    logic        adsp_q = 1'b1;
    logic        strb_q = 1'b0;
    logic        gr_q   = 1'b0;
    int          n;

    always @(posedge clk) begin
        adsp_q <= ads_n;
        // requester cycles while granted are not memory cycles of ours
        strb_q <= !(rd_n && wr_n) && ack_n;
        if (gap_q != 8'hff)
            gap_q <= gap_q + 8'h01;
        // a grant between two cycles is logged as a gap of zero
        if (!ack_n)
            gr_q <= 1'b1;
        if (!ads_n && ack_n) begin
            addr_q <= {ua, ad};
            kind_q <= {hbe_n, a0};
        end
        // clocks between cycle starts
        if (!ads_n && adsp_q && ack_n) begin
            gapl_q <= gr_q ? 8'h00 : gap_q;
            gr_q   <= 1'b0;
            gap_q  <= 8'h01;
            data_q <= 16'h0;
        end
        if (!wr_n)
            data_q <= ad;
        if (strb_q && rd_n && wr_n && ack_n)
            log_q.push_back({gapl_q, addr_q, kind_q,
                             kind_q[1] ? 8'h0 : data_q[15:8],
                             kind_q[0] ? 8'h0 : data_q[7:0]});
    end

    initial begin
        bus_req_n = 1'b1;
        ads_drv   = 1'b0;
        ads_v     = 1'b1;
        data_direction_n_v    = 1'b1;
        forever begin
            @(negedge clk);
            if (dma_go && rst_b) begin
                bus_req_n <= 1'b0;
                n = 0;
                do begin
                    @(negedge clk);
                    n++;
                end while (ack_n !== 1'b0 && n < 60);
                ads_drv <= 1'b1;
                ads_v   <= 1'b0;
                data_direction_n_v  <= dma_dir;
                @(negedge clk);
                ads_v <= 1'b1;
                repeat (5) @(negedge clk);
                // released line shows the inverse, not the old level
                ads_drv   <= 1'b0;
                data_direction_n_v    <= !dma_dir;
                bus_req_n <= 1'b1;
                while (dma_go) @(negedge clk);
            end
        end
    end
endmodule
`default_nettype wire

// file: bus_access_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module bus_access_sequencer_test;
    import bas_pkg::*;
    logic        clk, rst_b, op_req, op_write, op_half_go, instr_start;
    logic        psr_user, locked_insn, bus_req_n, dma_go, dma_dir;
    logic [23:0] op_addr;
    logic [1:0]  op_size;
    logic [63:0] op_wdata;
    logic [3:0]  cyc_status_in, cycle_status;
    logic [15:0] addr_data_bus_o, addr_data_bus_oe;
    logic [7:0]  upper_address_o;
    logic        op_busy, op_half_done, op_done, bus_grant_ack_n, ale;
    logic        upper_address_oe, addr_bit_zero, high_byte_enable_n;
    logic        high_byte_enable_oe, address_strobe_n_o;
    logic        address_strobe_n_oe, data_direction_n_o;
    logic        data_direction_n_oe, timing_state_out_n, rd_n, wr_n;
    logic        data_buffer_en_n, instr_begin_pulse_n, user_mode;
    logic        interlock_active_n, ads_drv, ads_v, data_direction_n_v;
    logic [42:0] exp_q[$];
    logic [31:0] r, s;
    int          errors, n_compared, cyc, dma_wr, dma_rd, bad_gr, k;
    // strobe has a pull-up once nobody drives it
    wire address_strobe_n_i = address_strobe_n_oe ? address_strobe_n_o
                            : ads_drv ? ads_v : 1'b1;
    wire data_direction_n_i = data_direction_n_oe ? data_direction_n_o
                            : data_direction_n_v;

    bas_seq i_dut (.clk, .rst_b, .op_req, .op_addr, .op_size, .op_write,
        .op_wdata, .op_busy, .op_half_done, .op_half_go, .op_done,
        .instr_start, .psr_user, .locked_insn, .cyc_status_in, .bus_req_n,
        .bus_grant_ack_n, .addr_data_bus_o, .addr_data_bus_oe,
        .upper_address_o, .upper_address_oe, .addr_bit_zero,
        .high_byte_enable_n, .high_byte_enable_oe, .address_strobe_n_o,
        .address_strobe_n_oe, .address_strobe_n_i, .data_direction_n_o,
        .data_direction_n_oe, .data_direction_n_i, .ale,
        .timing_state_out_n, .data_buffer_en_n, .rd_n, .wr_n,
        .cycle_status, .instr_begin_pulse_n, .user_mode,
        .interlock_active_n);
    // undriven lanes show the inverse of the last value
    bas_mem_model i_mem (.clk, .rst_b,
        .ad(addr_data_bus_o ^ ~addr_data_bus_oe),
        .ua(upper_address_o), .a0(addr_bit_zero),
        .hbe_n(high_byte_enable_n), .ads_n(address_strobe_n_i), .rd_n,
        .wr_n, .ack_n(bus_grant_ack_n), .dma_go, .dma_dir, .bus_req_n,
        .ads_drv, .ads_v, .data_direction_n_v);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
        if (rst_b && bus_grant_ack_n === 1'b0) begin
            if (|{addr_data_bus_oe, upper_address_oe, high_byte_enable_oe,
                  address_strobe_n_oe, data_direction_n_oe} || !ale)
                bad_gr++;
            if (locked_insn && interlock_active_n !== 1'b0)
                bad_gr++;
            if (!wr_n && !data_buffer_en_n)
                dma_wr++;
            if (!rd_n && !data_buffer_en_n)
                dma_rd++;
        end
    end

    // cycles an operand should take, lanes of the bench's own reckoning
    task automatic split(input logic [23:0] a, input int n,
                         input logic [63:0] d, input logic wr);
        int i;
        logic f;
        i = 0;
        f = 1'b1;
        if (!wr)
            d = '0;
        while (i < n) begin
            if (a[0]) begin
                exp_q.push_back({f, a, KIND_ODD_BYTE, d[8*i+:8], 8'h0});
                i++;
                a++;
            end else if (n - i > 1) begin
                exp_q.push_back({f, a, KIND_EVEN_WORD, d[8*i+8+:8],
                                 d[8*i+:8]});
                i += 2;
                a += 2;
            end else begin
                exp_q.push_back({f, a, KIND_EVEN_BYTE, 8'h0, d[8*i+:8]});
                i++;
            end
            f = 1'b0;
        end
    endtask

    task automatic run_op(input logic [23:0] a, input logic [1:0] sz,
                          input logic [63:0] d, input logic wr,
                          input int gr_at);
        logic [49:0] g;
        logic [42:0] e;
        int n;
        int j;
        {op_addr, op_size, op_wdata, op_write, op_req} = {a, sz, d, wr, 1'b1};
        @(negedge clk);
        op_req = 1'b0;
        check("busy", op_busy, 1'b1);
        split(a, sz == 2'h3 ? 4 : 1 << sz, d, wr);
        n = 0;
        if (sz == 2'h3) begin
            while (op_half_done !== 1'b1 && n < 300) begin
                @(negedge clk);
                n++;
            end
            check("half_done", op_half_done, 1'b1);
            op_half_go = 1'b1;
            @(negedge clk);
            op_half_go = 1'b0;
            split(a + 24'h4, 4, d >> 32, wr);
        end
        while (op_done !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check("done", op_done, 1'b1);
        repeat (2) @(negedge clk);
        j = 0;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            g = i_mem.log_q.size() > 0 ? i_mem.log_q.pop_front() : '0;
            check("cycle", g[41:0], e[41:0]);
            if (!e[42])
                check("gap", g[49:42], j == gr_at ? 8'h00 : 8'h04);
            j++;
        end
    endtask

    task automatic dma(input logic dir, input int lim);
        int n;
        {dma_wr, dma_rd, n} = '0;
        dma_dir <= dir;
        dma_go  <= 1'b1;
        while (bus_req_n !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (bus_grant_ack_n !== 1'b0 && n < 60) begin
            @(negedge clk);
            n++;
        end
        check("grant", n <= lim, 1'b1);
        dma_go <= 1'b0;
        n = 0;
        while (bus_req_n !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (bus_grant_ack_n !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        check("release", n <= 3, 1'b1);
        check("dma_wr", dma_wr > 0, dir);
        check("dma_rd", dma_rd > 0, !dir);
    endtask

    initial begin
        {rst_b, op_req, op_write, op_half_go, instr_start} = '0;
        {psr_user, locked_insn, dma_go, dma_dir} = '0;
        {op_addr, op_size, op_wdata, cyc_status_in} = '0;
        r = $urandom(32'hc95954cb);
        repeat (5) @(negedge clk);
        check("ack_rst", bus_grant_ack_n, 1'b1);
        check("ale_rst", ale, 1'b0);
        rst_b = 1'b1;
        for (k = 0; k < 16; k++) begin
            r = $urandom;
            s = $urandom;
            run_op({r[23:1], k[2]}, k[1:0], {r, s}, s[0] | !k[3], -1);
        end
        dma(1'b1, 3);
        locked_insn = 1'b1;
        dma(1'b0, 3);
        locked_insn = 1'b0;
        // request lands in T3 of the second of three cycles: grant follows
        // that T4, so only the third cycle comes after the grant
        fork
            run_op(24'h000fff, 2'h2, {$urandom, $urandom}, 1'b1, 2);
            begin
                repeat (6) @(negedge clk);
                dma(1'b1, 24);
            end
        join
        check("granted_bus", bad_gr, 0);
        for (k = 0; k < 12; k++) begin
            r = $urandom;
            {cyc_status_in, locked_insn, psr_user} = r[5:0];
            instr_start = 1'b1;
            @(negedge clk);
            instr_start = 1'b0;
            check("user", user_mode, r[0]);
            check("ilo", interlock_active_n, !r[1]);
            check("status", cycle_status, r[5:2]);
            check("pfs", instr_begin_pulse_n, 1'b0);
            @(negedge clk);
            check("pfs_end", instr_begin_pulse_n, 1'b1);
        end
        check("extra", i_mem.log_q.size(), 0);
        conclude();
    end
endmodule
`default_nettype wire
